// ### fsma_pkg.sv
// constants for the fault status and mask aggregator
package fsma_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] FSMA_OFS_ALARM_MASK = 8'h1d;
	localparam logic [7:0] FSMA_OFS_GEN_MASK = 8'h1e;
	localparam logic [7:0] FSMA_OFS_FAULT = 8'h20;
	localparam logic [7:0] FSMA_OFS_GEN_STAT = 8'h21;
	localparam logic [7:0] FSMA_OFS_FORCE = 8'h23;

	// ==========================================================
	// reset values
	localparam logic [15:0] FSMA_RST_ALARM_MASK = 16'hefdf;
	localparam logic [15:0] FSMA_RST_GEN_MASK = 16'hffff;
	localparam logic [15:0] FSMA_RST_FAULT = 16'h0200;
	localparam logic [15:0] FSMA_RST_GEN_STAT = 16'h1180;
	localparam logic [2:0] FSMA_RST_FORCE = 3'h0;

	// ==========================================================
	// writable and read-as-one bits of the mask registers
	localparam logic [15:0] FSMA_GEN_MASK_WR = 16'h00cf;
	localparam logic [15:0] FSMA_GEN_MASK_RSV = 16'hff30;
	localparam logic [15:0] FSMA_ALARM_MASK_WR = 16'h31ff;
	localparam logic [15:0] FSMA_ALARM_MASK_RSV = 16'hce00;

	// ==========================================================
	// fault status word fields
	localparam int FSMA_F_GENERAL_IRQ_SUMMARY = 15;
	localparam int FSMA_F_SELF_DIAG = 13;
	localparam int FSMA_F_OSC = 12;
	localparam int FSMA_F_CNT_HI = 11;
	localparam int FSMA_F_CNT_LO = 10;
	localparam int FSMA_F_TRIM_NL = 9;
	localparam int FSMA_F_TRIM_CRC = 8;
	localparam int FSMA_F_FRAME_CRC = 7;
	localparam int FSMA_F_WDOG = 6;
	localparam int FSMA_F_VREF = 5;
	localparam int FSMA_F_IN1 = 4;
	localparam int FSMA_F_IN0 = 3;
	localparam int FSMA_F_TEMP = 2;
	localparam int FSMA_F_OTERR = 1;
	localparam int FSMA_F_OTWARN = 0;
	// bits that feed the interrupt summary
	localparam logic [15:0] FSMA_FAULT_IRQ_BITS = 16'h21ff;
	// sticky bits cleared by a read
	localparam logic [15:0] FSMA_FAULT_STICKY = 16'h01c0;

	// ==========================================================
	// general status word fields
	localparam int FSMA_G_ALARM_IRQ = 15;
	localparam int FSMA_G_TRIM_BUSY = 12;
	localparam int FSMA_G_RESET = 8;
	localparam int FSMA_G_SLEW = 7;
	localparam int FSMA_G_EOC = 6;
	localparam int FSMA_G_ADC_BUSY = 5;
	localparam int FSMA_G_PVDD = 4;
	localparam int FSMA_G_BRK_FRM = 3;
	localparam int FSMA_G_BRK_PAR = 2;
	localparam int FSMA_G_SER_FRM = 1;
	localparam int FSMA_G_SER_PAR = 0;
	localparam logic [15:0] FSMA_GENERAL_IRQ_SUMMARY_BITS = 16'h00cf;
	localparam logic [15:0] FSMA_GEN_STICKY = 16'h014f;

	// ==========================================================
	// force-fail register fields
	localparam int FSMA_FF_VREF = 2;
	localparam int FSMA_FF_OTERR = 1;
	localparam int FSMA_FF_OTWARN = 0;

	// ==========================================================
	// synchronised condition vector layout
	localparam int FSMA_S_SELF_DIAG = 0;
	localparam int FSMA_S_OSC = 1;
	localparam int FSMA_S_TRIM_DONE = 2;
	localparam int FSMA_S_TRIM_CRC = 3;
	localparam int FSMA_S_FRAME_CRC = 4;
	localparam int FSMA_S_WDOG = 5;
	localparam int FSMA_S_VREF = 6;
	localparam int FSMA_S_IN1 = 7;
	localparam int FSMA_S_IN0 = 8;
	localparam int FSMA_S_TEMP = 9;
	localparam int FSMA_S_OTERR = 10;
	localparam int FSMA_S_OTWARN = 11;
	localparam int FSMA_S_SLEW = 12;
	localparam int FSMA_S_EOC = 13;
	localparam int FSMA_S_BRK_FRM = 14;
	localparam int FSMA_S_BRK_PAR = 15;
	localparam int FSMA_S_SER_FRM = 16;
	localparam int FSMA_S_SER_PAR = 17;
	localparam int FSMA_S_ADC_BUSY = 18;
	localparam int FSMA_S_PVDD = 19;
	localparam int FSMA_S_TRIM_BUSY = 20;
	localparam int FSMA_S_LIMIT8 = 21;
	localparam int FSMA_S_CNT0 = 22;
	localparam int FSMA_S_CNT1 = 23;
	localparam int FSMA_S_CNT2 = 24;
	localparam int FSMA_S_WIDTH = 25;

endpackage

// ### fsma_sync.sv
// two-stage level synchroniser for a vector of condition inputs
`timescale 1ns/1ps

module fsma_sync
#(
	parameter int WIDTH = 1
)
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	typedef struct packed
	{
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} fsma_sync_state_t;

	fsma_sync_state_t st;
	fsma_sync_state_t next_st;

	always_comb
	begin
		next_st.meta = async_i;
		next_st.sync = st.meta;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign sync_o = st.sync;

endmodule

// ### fsma_top.sv
// fault status and mask aggregation with a simple register port
`timescale 1ns/1ps

// Notes on behaviour
// - general mask bit 0 lets its condition interrupt; 1 (reset) blocks irq and alarm
// - status bits set whenever the condition exists, masks gate only irq, alarm and the bit 15 summaries
// - general mask: slew 7, eoc 6, break frame 3, break parity 2, serial 1 and 0
// - general mask bits 15-8 read ffh, bits 5-4 read 3h
// - fault word bit 15 is the OR of unmasked general status bits
// - fault word bit 13 high when any self-diagnostic channel failed
// - fault word bit 12 oscillator failure forces alarm, never feeds interrupt
// - fault bits 11-10 show crc counter bits 1:0, or 2:1 when limit is 8
// - fault bit 9 resets to 1, clears after first trim load, holds alarm only
// - fault bit 8 sets on trim memory crc failure, maskable
// - fault bit 7 sets on bad serial frame crc, maskable
// - fault bit 6 sets on watchdog fault, maskable
// - fault bits 8,7,6 sticky; a read clears them unless the cause persists
// - fault bit 5 is live reference-invalid ORed with its force bit, maskable
// - fault bits 4,3,2 are input1, input0 and temperature threshold faults, maskable
// - fault bit 1 is live overtemperature error ORed with force bit, maskable
// - fault bit 0 is live temperature warning ORed with force bit, maskable
// - general mask resets to ffffh, fault word to 0200h
// - alarm mask bits 13 and 8-0: 0 lets its condition interrupt; 1 blocks irq and alarm
// - general status bit 15 is the OR of unmasked fault word bits 13 and 8-0
// - eoc, break frame, break parity, serial frame and serial parity status sticky, cleared on read unless persisting
module fsma_top
	import fsma_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// diagnostic and fault conditions
	input wire logic self_diag_fault_i,
	input wire logic osc_start_failure_i,
	input wire logic trim_load_done_i,
	input wire logic trim_busy_i,
	input wire logic trim_crc_err_i,
	input wire logic frame_crc_err_i,
	input wire logic watchdog_err_i,
	input wire logic reference_invalid_i,
	input wire logic input1_range_fault_i,
	input wire logic input0_range_fault_i,
	input wire logic temp_range_fault_i,
	input wire logic overtemp_error_i,
	input wire logic overtemp_warning_i,
	// crc fault counter
	input wire logic [2:0] crc_err_count_i,
	input wire logic crc_limit_is8_i,
	// general events
	input wire logic slew_done_i,
	input wire logic conv_done_i,
	input wire logic adc_busy_i,
	input wire logic pvdd_high_i,
	input wire logic break_frame_err_i,
	input wire logic break_parity_err_i,
	input wire logic serial_frame_err_i,
	input wire logic serial_parity_err_i,
	// outputs
	output logic irq_o,
	output logic alarm_n_o
);

	// ==========================================================
	// state
	typedef struct packed
	{
		logic [15:0] gen_mask;
		logic [15:0] alarm_mask;
		logic [15:0] fault;
		logic [15:0] gen_stat;
		logic [2:0] force_fail;
		logic [15:0] rdata;
		logic irq;
		logic alarm_n;
	} fsma_state_t;

	fsma_state_t st;
	fsma_state_t next_st;

	logic [FSMA_S_WIDTH-1:0] cond_raw;
	logic [FSMA_S_WIDTH-1:0] cond;

	// ==========================================================
	// input synchronisers
	assign cond_raw = {
		crc_err_count_i[2],
		crc_err_count_i[1],
		crc_err_count_i[0],
		crc_limit_is8_i,
		trim_busy_i,
		pvdd_high_i,
		adc_busy_i,
		serial_parity_err_i,
		serial_frame_err_i,
		break_parity_err_i,
		break_frame_err_i,
		conv_done_i,
		slew_done_i,
		overtemp_warning_i,
		overtemp_error_i,
		temp_range_fault_i,
		input0_range_fault_i,
		input1_range_fault_i,
		reference_invalid_i,
		watchdog_err_i,
		frame_crc_err_i,
		trim_crc_err_i,
		trim_load_done_i,
		osc_start_failure_i,
		self_diag_fault_i
	};

	fsma_sync #(
		.WIDTH(FSMA_S_WIDTH)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.async_i(cond_raw),
		.sync_o(cond)
	);

	// ==========================================================
	// next state
	logic rd_fault;
	logic rd_gen;
	logic [15:0] f_cond;
	logic [15:0] g_cond;
	logic [15:0] f_live;
	logic [15:0] g_live;
	logic [1:0] cnt_view;
	logic general_irq_summary;
	logic alarm_irq;
	logic alarm_any;

	always_comb
	begin
		next_st = st;
		rd_fault = reg_rd_i && (reg_addr_i == FSMA_OFS_FAULT);
		rd_gen = reg_rd_i && (reg_addr_i == FSMA_OFS_GEN_STAT);

		// fault word: sticky causes and live levels
		f_cond = 16'h0000;
		f_cond[FSMA_F_TRIM_CRC] = cond[FSMA_S_TRIM_CRC];
		f_cond[FSMA_F_FRAME_CRC] = cond[FSMA_S_FRAME_CRC];
		f_cond[FSMA_F_WDOG] = cond[FSMA_S_WDOG];

		if (cond[FSMA_S_LIMIT8])
			cnt_view = {cond[FSMA_S_CNT2], cond[FSMA_S_CNT1]};
		else
			cnt_view = {cond[FSMA_S_CNT1], cond[FSMA_S_CNT0]};

		f_live = 16'h0000;
		f_live[FSMA_F_SELF_DIAG] = cond[FSMA_S_SELF_DIAG];
		f_live[FSMA_F_OSC] = cond[FSMA_S_OSC];
		f_live[FSMA_F_CNT_HI] = cnt_view[1];
		f_live[FSMA_F_CNT_LO] = cnt_view[0];
		// once loaded, the flag stays clear until the next reset
		f_live[FSMA_F_TRIM_NL] = st.fault[FSMA_F_TRIM_NL] & ~cond[FSMA_S_TRIM_DONE];
		f_live[FSMA_F_VREF] = cond[FSMA_S_VREF] | st.force_fail[FSMA_FF_VREF];
		f_live[FSMA_F_IN1] = cond[FSMA_S_IN1];
		f_live[FSMA_F_IN0] = cond[FSMA_S_IN0];
		f_live[FSMA_F_TEMP] = cond[FSMA_S_TEMP];
		f_live[FSMA_F_OTERR] = cond[FSMA_S_OTERR] | st.force_fail[FSMA_FF_OTERR];
		f_live[FSMA_F_OTWARN] = cond[FSMA_S_OTWARN] | st.force_fail[FSMA_FF_OTWARN];

		// general status word
		g_cond = 16'h0000;
		g_cond[FSMA_G_EOC] = cond[FSMA_S_EOC];
		g_cond[FSMA_G_BRK_FRM] = cond[FSMA_S_BRK_FRM];
		g_cond[FSMA_G_BRK_PAR] = cond[FSMA_S_BRK_PAR];
		g_cond[FSMA_G_SER_FRM] = cond[FSMA_S_SER_FRM];
		g_cond[FSMA_G_SER_PAR] = cond[FSMA_S_SER_PAR];

		g_live = 16'h0000;
		g_live[FSMA_G_TRIM_BUSY] = cond[FSMA_S_TRIM_BUSY];
		g_live[FSMA_G_SLEW] = cond[FSMA_S_SLEW];
		g_live[FSMA_G_ADC_BUSY] = cond[FSMA_S_ADC_BUSY];
		g_live[FSMA_G_PVDD] = cond[FSMA_S_PVDD];

		// summaries from the registered words, masks touch status only through the bit 15 summaries
		general_irq_summary = |(st.gen_stat & FSMA_GENERAL_IRQ_SUMMARY_BITS & ~st.gen_mask);
		alarm_irq = |(st.fault & FSMA_FAULT_IRQ_BITS & ~st.alarm_mask);

		// sticky: a new cause wins over the read that clears it
		next_st.fault = (st.fault & FSMA_FAULT_STICKY & ~{16{rd_fault}})
			| f_cond | f_live;
		next_st.fault[FSMA_F_GENERAL_IRQ_SUMMARY] = general_irq_summary;
		next_st.gen_stat = (st.gen_stat & FSMA_GEN_STICKY & ~{16{rd_gen}})
			| g_cond | g_live;
		next_st.gen_stat[FSMA_G_ALARM_IRQ] = alarm_irq;

		// oscillator failure and unloaded trim force the alarm
		alarm_any = general_irq_summary | alarm_irq
			| st.fault[FSMA_F_OSC] | st.fault[FSMA_F_TRIM_NL];
		next_st.alarm_n = ~alarm_any;
		next_st.irq = general_irq_summary | alarm_irq;

		// register writes
		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				FSMA_OFS_GEN_MASK:
					next_st.gen_mask = (reg_wdata_i & FSMA_GEN_MASK_WR) | FSMA_GEN_MASK_RSV;
				FSMA_OFS_ALARM_MASK:
					next_st.alarm_mask = (reg_wdata_i & FSMA_ALARM_MASK_WR) | FSMA_ALARM_MASK_RSV;
				FSMA_OFS_FORCE:
					next_st.force_fail = reg_wdata_i[2:0];
				default:
					next_st.rdata = next_st.rdata;
			endcase
		end

		// register reads, data stands for one cycle
		next_st.rdata = 16'h0000;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				FSMA_OFS_GEN_MASK:
					next_st.rdata = st.gen_mask;
				FSMA_OFS_ALARM_MASK:
					next_st.rdata = st.alarm_mask;
				FSMA_OFS_FAULT:
					next_st.rdata = st.fault;
				FSMA_OFS_GEN_STAT:
					next_st.rdata = st.gen_stat;
				FSMA_OFS_FORCE:
					next_st.rdata = {13'h0000, st.force_fail};
				default:
					next_st.rdata = 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st.gen_mask <= FSMA_RST_GEN_MASK;
			st.alarm_mask <= FSMA_RST_ALARM_MASK;
			st.fault <= FSMA_RST_FAULT;
			st.gen_stat <= FSMA_RST_GEN_STAT;
			st.force_fail <= FSMA_RST_FORCE;
			st.rdata <= 16'h0000;
			st.irq <= 1'b0;
			st.alarm_n <= 1'b1;
		end
		else
			st <= next_st;
	end

	// ==========================================================
	// outputs
	assign reg_rdata_o = st.rdata;
	assign irq_o = st.irq;
	assign alarm_n_o = st.alarm_n;

endmodule

// ### fsma_properties.sv
// port assertions for the fault status and mask aggregator
`timescale 1ns/1ps

module fsma_properties
	import fsma_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	// conditions
	input wire logic self_diag_fault_i,
	input wire logic osc_start_failure_i,
	input wire logic frame_crc_err_i,
	input wire logic watchdog_err_i,
	input wire logic reference_invalid_i,
	input wire logic overtemp_error_i,
	// outputs
	input wire logic irq_o,
	input wire logic alarm_n_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	// ==========================================================
	// sequences
	sequence rd_fault;
		reg_rd_i && reg_addr_i == FSMA_OFS_FAULT;
	endsequence
	sequence rd_gen;
		reg_rd_i && reg_addr_i == FSMA_OFS_GEN_STAT;
	endsequence
	property live_bit(c, int b);
		c[*4] ##0 rd_fault |=> reg_rdata_o[b];
	endproperty

	// ==========================================================
	// assertions
	a_diag_seen: assert property (live_bit(self_diag_fault_i, 13)) else $error("diag bit low");
	a_frame_crc: assert property (live_bit(frame_crc_err_i, 7)) else $error("frame crc bit low");
	a_wdog_seen: assert property (live_bit(watchdog_err_i, 6)) else $error("watchdog bit low");
	a_ref_live: assert property (live_bit(reference_invalid_i, 5)) else $error("reference bit low");
	a_otemp_err: assert property (live_bit(overtemp_error_i, 1)) else $error("overtemp bit low");
	a_sticky_hold: assert property (watchdog_err_i[*4] ##0 rd_fault ##1 (rd_fault and watchdog_err_i) |=>
		reg_rdata_o[6]) else $error("sticky bit lost");
	a_osc_alarm: assert property (osc_start_failure_i[*4] |=> !alarm_n_o) else $error("osc alarm high");
	a_trim_boot: assert property ($rose(nrst_i) |=> !alarm_n_o) else $error("boot alarm high");
	a_irq_fault: assert property (rd_fault ##1 reg_rdata_o[15] |-> irq_o || $past(irq_o)) else $error("irq low");
	a_alarm_gen: assert property (rd_gen ##1 reg_rdata_o[15] |-> !alarm_n_o || !$past(alarm_n_o))
		else $error("alarm high");
	a_mask_rsv: assert property (reg_rd_i && reg_addr_i == FSMA_OFS_GEN_MASK |=>
		reg_rdata_o[15:8] == 8'hff && reg_rdata_o[5:4] == 2'h3) else $error("mask reserved bits");
endmodule

// ### tb.sv
// self-checking bench for the fault status and mask aggregator
`timescale 1ns/1ps

module tb
	import fsma_pkg::*;
;
	typedef struct {logic [15:0] e; logic [15:0] m;} fsma_note_t;
	logic sys_clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, osc = 1'b0, done = 1'b0, lim8 = 1'b0;
	logic pend = 1'b0, irq_o, alarm_n_o;
	logic [7:0] reg_addr_i = 8'h00, sa, ma;
	logic [15:0] reg_wdata_i = 16'h0000, cv = 16'h0000, reg_rdata_o;
	logic [2:0] cnt = 3'h0, aux = 3'h0;
	logic [31:0] lf = 32'h535a5398;
	int n_fail = 0, tests_run = 0;
	int bp[16] = '{13, 8, 7, 6, 5, 4, 3, 2, 1, 0, 7, 6, 3, 2, 1, 0};
	fsma_note_t q[$], n;

	fsma_top u_fsma_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .self_diag_fault_i(cv[0]),
		.osc_start_failure_i(osc), .trim_load_done_i(done), .trim_busy_i(aux[2]), .trim_crc_err_i(cv[1]),
		.frame_crc_err_i(cv[2]), .watchdog_err_i(cv[3]), .reference_invalid_i(cv[4]), .input1_range_fault_i(cv[5]),
		.input0_range_fault_i(cv[6]), .temp_range_fault_i(cv[7]), .overtemp_error_i(cv[8]),
		.overtemp_warning_i(cv[9]), .crc_err_count_i(cnt), .crc_limit_is8_i(lim8), .slew_done_i(cv[10]),
		.conv_done_i(cv[11]), .adc_busy_i(aux[1]), .pvdd_high_i(aux[0]), .break_frame_err_i(cv[12]),
		.break_parity_err_i(cv[13]), .serial_frame_err_i(cv[14]), .serial_parity_err_i(cv[15]), .irq_o(irq_o),
		.alarm_n_o(alarm_n_o));

	initial
	begin
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_rd_i <= 1'b0;
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		q.push_back('{e, m});
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
	endtask
	task automatic idle(input int k);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		repeat (k) @(posedge sys_clk_i);
	endtask
	task automatic pin(input logic ei, input logic ea);
		idle(0);
		@(negedge sys_clk_i);
		chk("irq_o", {15'h0, ei}, {15'h0, irq_o});
		chk("alarm_n_o", {15'h0, ea}, {15'h0, alarm_n_o});
		@(posedge sys_clk_i);
	endtask
	task automatic fin(input string s);
		idle(2);
		$display("test %s done", s);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// read results stand in the cycle after the strobe
	always @(negedge sys_clk_i)
	begin
		if (pend)
		begin
			n = q.pop_front();
			chk("rdata", n.e & n.m, reg_rdata_o & n.m);
		end
		pend = reg_rd_i;
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		summarize();
	end

	// ==========================================================
	// tests
	initial
	begin
		repeat (6) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		rd(FSMA_OFS_GEN_MASK, FSMA_RST_GEN_MASK, 16'hffff);
		rd(FSMA_OFS_FAULT, FSMA_RST_FAULT, 16'hffff);
		rd(FSMA_OFS_ALARM_MASK, FSMA_RST_ALARM_MASK, 16'hffff);
		rd(8'h1f, 16'h0000, 16'hffff);
		pin(1'b0, 1'b0);
		done <= 1'b1;
		idle(5);
		rd(FSMA_OFS_FAULT, 16'h0000, 16'h0200);
		pin(1'b0, 1'b1);
		fin("reset");
		repeat (4)
		begin
			lf = lfsr(lf);
			aux <= lf[18:16];
			wr(FSMA_OFS_GEN_MASK, lf[15:0]);
			rd(FSMA_OFS_GEN_MASK, lf[15:0] | FSMA_GEN_MASK_RSV, 16'hffff);
			wr(FSMA_OFS_FAULT, lf[31:16]);
		end
		wr(FSMA_OFS_GEN_MASK, 16'hffff);
		wr(FSMA_OFS_ALARM_MASK, 16'hffff);
		idle(4);
		rd(FSMA_OFS_FAULT, 16'h0000, 16'hffff);
		rd(FSMA_OFS_GEN_STAT, {3'h0, aux[2], 6'h0, aux[1:0], 4'h0}, 16'h1030);
		fin("masks");
		for (int i = 0; i < 16; i++)
		begin
			sa = (i < 10) ? FSMA_OFS_FAULT : FSMA_OFS_GEN_STAT;
			ma = (i < 10) ? FSMA_OFS_ALARM_MASK : FSMA_OFS_GEN_MASK;
			cv[i] <= 1'b1;
			idle(4);
			rd(sa, 16'hffff, 16'h1 << bp[i]);
			rd(sa, 16'hffff, 16'h1 << bp[i]);
			pin(1'b0, 1'b1);
			wr(ma, ~(16'h1 << bp[i]));
			idle(2);
			pin(1'b1, 1'b0);
			rd(sa ^ 8'h01, 16'h8000, 16'h8000);
			wr(ma, 16'hffff);
			cv[i] <= 1'b0;
			idle(4);
			rd(sa, ((i > 0 && i < 4) || i > 10) ? 16'hffff : 16'h0000, 16'h1 << bp[i]);
			rd(sa, 16'h0000, 16'h1 << bp[i]);
		end
		fin("conditions");
		wr(FSMA_OFS_FORCE, 16'h0007);
		idle(3);
		rd(FSMA_OFS_FAULT, 16'h0023, 16'h0023);
		wr(FSMA_OFS_FORCE, 16'h0000);
		osc <= 1'b1;
		wr(FSMA_OFS_ALARM_MASK, 16'hefff);
		idle(4);
		pin(1'b0, 1'b0);
		rd(FSMA_OFS_FAULT, 16'h1000, 16'h9000);
		osc <= 1'b0;
		cnt <= 3'h5;
		idle(4);
		rd(FSMA_OFS_FAULT, 16'h0400, 16'h0c00);
		lim8 <= 1'b1;
		idle(4);
		rd(FSMA_OFS_FAULT, 16'h0800, 16'h0c00);
		fin("force osc count");
		summarize();
	end
endmodule

bind fsma_top fsma_properties u_fsma_properties (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .self_diag_fault_i(self_diag_fault_i),
	.osc_start_failure_i(osc_start_failure_i), .frame_crc_err_i(frame_crc_err_i), .watchdog_err_i(watchdog_err_i),
	.reference_invalid_i(reference_invalid_i), .overtemp_error_i(overtemp_error_i), .irq_o(irq_o),
	.alarm_n_o(alarm_n_o));
